/* rbc_pkg.sv */
// Constants, field layouts and carrier types for the received buffer counter block
//
// Behaviour
// - Written decrement bit lowers count by one
// - Decrement bit is a strobe, reads zero
// - Simultaneous increment and decrement keep count
// - Writing zero to decrement bit does nothing
// - Control bits three to one read zero
// - Decrement touches receive accounting, never transmit
// - Count readable at status 23:16, compared against watermarks
`default_nettype none

package rbc_pkg;

   // Bus geometry and count width
   localparam int unsigned RBC_ADR_W = 8;
   localparam int unsigned RBC_DAT_W = 32;
   localparam int unsigned RBC_SEL_W = 4;
   localparam int unsigned RBC_CNT_W = 8;

   // Register byte offsets
   localparam logic [7:0] RBC_CTRL1_OFS = 8'h00;
   localparam logic [7:0] RBC_WMARK_OFS = 8'h04;
   localparam logic [7:0] RBC_STAT_OFS  = 8'h08;

   // Control register 1 field positions
   localparam int unsigned RBC_ON_BIT     = 15;
   localparam int unsigned RBC_RECEIVE_ENABLE_BIT   = 8;
   localparam int unsigned RBC_AUTOFC_BIT = 7;
   localparam int unsigned RBC_MANFC_BIT  = 4;
   localparam int unsigned RBC_DEC_BIT    = 0;

   // Watermark register field positions
   localparam int unsigned RBC_EMPTY_WM_LSB = 0;
   localparam int unsigned RBC_FULL_WM_LSB  = 8;

   // Status register field positions
   localparam int unsigned RBC_FC_ACT_BIT = 0;
   localparam int unsigned RBC_FULL_BIT   = 1;
   localparam int unsigned RBC_ZERO_BIT   = 2;
   localparam int unsigned RBC_CNT_LSB    = 16;

   // Values after reset, and the count ceiling
   localparam logic [7:0] RBC_FULL_WM_RST  = 8'hFF;
   localparam logic [7:0] RBC_EMPTY_WM_RST = 8'h00;
   localparam logic [7:0] RBC_CNT_RST      = 8'h00;
   localparam logic [7:0] RBC_CNT_MAX      = 8'hFF;

   // Control fields held by software
   typedef struct packed {
      logic on;
      logic receive_enable;
      logic auto_fc;
      logic manual_fc;
   } rbc_ctrl_t;

   // One accepted bus access, valid for a single cycle
   typedef struct packed {
      logic                 wr;
      logic                 rd;
      logic [RBC_ADR_W-1:0] ofs;
      logic [RBC_SEL_W-1:0] sel;
      logic [RBC_DAT_W-1:0] wdata;
   } rbc_access_t;

   localparam rbc_ctrl_t RBC_CTRL_RST = '{on: 1'b0, receive_enable: 1'b0,
                                         auto_fc: 1'b0, manual_fc: 1'b0};

endpackage : rbc_pkg

`default_nettype wire

/* rbc_sat_counter.sv */
// Saturating up/down counter for received buffers
`timescale 1ns/100ps
`default_nettype none

module rbc_sat_counter
   import rbc_pkg::*;
#(
   parameter int unsigned W = 8
)
(
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Control
   input  wire logic         clr_i,
   input  wire logic         inc_i,
   input  wire logic         dec_i,
   // Count
   output logic [W-1:0]      count_o
);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;

   always_comb
   begin
      count_next = count_reg;
      if (clr_i)
      begin
         count_next = '0;
      end
      else if (inc_i && dec_i)
      begin
         count_next = count_reg;
      end
      else if (dec_i)
      begin
         // Underflow would fake a full buffer pool
         if (count_reg != '0)
         begin
            count_next = count_reg - {{(W-1){1'b0}}, 1'b1};
         end
      end
      else if (inc_i)
      begin
         if (count_reg != {W{1'b1}})
         begin
            count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count_reg <= '0;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   assign count_o = count_reg;

endmodule : rbc_sat_counter

`default_nettype wire

/* rbc_wb_slave.sv */
// Classic Wishbone slave front end: accepts one access, answers one cycle later
`timescale 1ns/100ps
`default_nettype none

module rbc_wb_slave
   import rbc_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [RBC_ADR_W-1:0]        wb_adr_i,
   input  wire logic [RBC_SEL_W-1:0]        wb_sel_i,
   input  wire logic [RBC_DAT_W-1:0]        wb_dat_i,
   output logic                             wb_ack_o,
   output logic [RBC_DAT_W-1:0]             wb_dat_o,
   // Register file side
   input  wire logic [RBC_DAT_W-1:0]        rdata_i,
   output var rbc_pkg::rbc_access_t         access_o
);

   import rbc_pkg::*;

   logic                 ack_reg;
   logic                 ack_next;
   logic [RBC_DAT_W-1:0] dat_reg;
   logic [RBC_DAT_W-1:0] dat_next;
   logic                 take;

   // No re-accept while ack stands, so a held request acts once
   assign take = wb_cyc_i && wb_stb_i && !ack_reg;

   always_comb
   begin
      access_o.wr    = take && wb_we_i;
      access_o.rd    = take && !wb_we_i;
      access_o.ofs   = {wb_adr_i[RBC_ADR_W-1:2], 2'b00};
      access_o.sel   = wb_sel_i;
      access_o.wdata = wb_dat_i;
      ack_next       = take;
      dat_next       = dat_reg;
      if (take && !wb_we_i)
      begin
         dat_next = rdata_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end
      else
      begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

endmodule : rbc_wb_slave

`default_nettype wire

/* rbc_top.sv */
// Received buffer counter with control, watermark and status registers
`timescale 1ns/100ps
`default_nettype none

module rbc_top
   import rbc_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [rbc_pkg::RBC_ADR_W-1:0] wb_adr_i,
   input  wire logic [rbc_pkg::RBC_SEL_W-1:0] wb_sel_i,
   input  wire logic [rbc_pkg::RBC_DAT_W-1:0] wb_dat_i,
   output logic                             wb_ack_o,
   output logic [rbc_pkg::RBC_DAT_W-1:0]    wb_dat_o,
   // Receive logic
   input  wire logic                        rx_buffer_filled_i,
   // Controller state
   output logic                             controller_on_o,
   output logic                             receive_enable_o,
   output logic [rbc_pkg::RBC_CNT_W-1:0]    received_buffer_count_o,
   output logic                             flow_control_pause_o
);

   import rbc_pkg::*;

   rbc_access_t          acc;
   logic [RBC_DAT_W-1:0] rdata;
   logic [RBC_CNT_W-1:0] cnt;

   rbc_ctrl_t            ctrl_reg;
   rbc_ctrl_t            ctrl_next;
   logic [7:0]           full_wm_reg;
   logic [7:0]           full_wm_next;
   logic [7:0]           empty_wm_reg;
   logic [7:0]           empty_wm_next;
   logic                 auto_fc_reg;
   logic                 auto_fc_next;
   logic                 pause_reg;
   logic                 pause_next;

   logic                 ctrl_hit;
   logic                 wmark_hit;
   logic                 stat_hit;
   logic                 dec_req;
   logic                 inc_req;
   logic                 cnt_clr;

   rbc_wb_slave u_slave (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_ack_o (wb_ack_o),
      .wb_dat_o (wb_dat_o),
      .rdata_i  (rdata),
      .access_o (acc)
   );

   assign ctrl_hit  = (acc.ofs == RBC_CTRL1_OFS);
   assign wmark_hit = (acc.ofs == RBC_WMARK_OFS);
   assign stat_hit  = (acc.ofs == RBC_STAT_OFS);

   // Only a one in bit 0 with its lane enabled asks for a decrement
   assign dec_req = acc.wr && ctrl_hit && acc.sel[0] && acc.wdata[RBC_DEC_BIT];
   assign inc_req = rx_buffer_filled_i && ctrl_reg.on;
   // Turning the controller off empties the buffer accounting
   assign cnt_clr = !ctrl_reg.on;

   // Decrement path reaches the counter only, never the pause logic
   rbc_sat_counter #(
      .W (RBC_CNT_W)
   ) u_count (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clr_i   (cnt_clr),
      .inc_i   (inc_req),
      .dec_i   (dec_req),
      .count_o (cnt)
   );

   // Control register: byte lanes 0 and 1 hold the fields
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (acc.wr && ctrl_hit)
      begin
         if (acc.sel[0])
         begin
            ctrl_next.auto_fc   = acc.wdata[RBC_AUTOFC_BIT];
            ctrl_next.manual_fc = acc.wdata[RBC_MANFC_BIT];
         end
         if (acc.sel[1])
         begin
            ctrl_next.on             = acc.wdata[RBC_ON_BIT];
            ctrl_next.receive_enable = acc.wdata[RBC_RECEIVE_ENABLE_BIT];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_reg <= RBC_CTRL_RST;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Watermark register
   always_comb
   begin
      full_wm_next  = full_wm_reg;
      empty_wm_next = empty_wm_reg;
      if (acc.wr && wmark_hit)
      begin
         if (acc.sel[0])
         begin
            empty_wm_next = acc.wdata[RBC_EMPTY_WM_LSB +: 8];
         end
         if (acc.sel[1])
         begin
            full_wm_next = acc.wdata[RBC_FULL_WM_LSB +: 8];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         full_wm_reg  <= RBC_FULL_WM_RST;
         empty_wm_reg <= RBC_EMPTY_WM_RST;
      end
      else
      begin
         full_wm_reg  <= full_wm_next;
         empty_wm_reg <= empty_wm_next;
      end
   end

   // Automatic flow control: hysteresis between the two watermarks
   always_comb
   begin
      auto_fc_next = auto_fc_reg;
      if (!ctrl_reg.on || !ctrl_reg.auto_fc)
      begin
         auto_fc_next = 1'b0;
      end
      else if (cnt >= full_wm_reg)
      begin
         auto_fc_next = 1'b1;
      end
      else if (cnt <= empty_wm_reg)
      begin
         auto_fc_next = 1'b0;
      end
      pause_next = ctrl_reg.on && (ctrl_reg.manual_fc || auto_fc_reg);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         auto_fc_reg <= 1'b0;
         pause_reg   <= 1'b0;
      end
      else
      begin
         auto_fc_reg <= auto_fc_next;
         pause_reg   <= pause_next;
      end
   end

   // Read data; unmapped offsets read zero
   always_comb
   begin
      rdata = '0;
      if (ctrl_hit)
      begin
         rdata[RBC_ON_BIT]     = ctrl_reg.on;
         rdata[RBC_RECEIVE_ENABLE_BIT]   = ctrl_reg.receive_enable;
         rdata[RBC_AUTOFC_BIT] = ctrl_reg.auto_fc;
         rdata[RBC_MANFC_BIT]  = ctrl_reg.manual_fc;
         // Bits 3:1 and the strobe stay zero from the default
      end
      else if (wmark_hit)
      begin
         rdata[RBC_EMPTY_WM_LSB +: 8] = empty_wm_reg;
         rdata[RBC_FULL_WM_LSB +: 8]  = full_wm_reg;
      end
      else if (stat_hit)
      begin
         rdata[RBC_CNT_LSB +: RBC_CNT_W] = cnt;
         rdata[RBC_FC_ACT_BIT]           = auto_fc_reg;
         rdata[RBC_FULL_BIT]             = (cnt == RBC_CNT_MAX);
         rdata[RBC_ZERO_BIT]             = (cnt == RBC_CNT_RST);
      end
   end

   assign controller_on_o         = ctrl_reg.on;
   assign receive_enable_o        = ctrl_reg.receive_enable;
   assign received_buffer_count_o = cnt;
   assign flow_control_pause_o    = pause_reg;

   default clocking cb @(posedge clk_i);
   endclocking

   default disable iff (rst_i);

   dec_by_one_a : assert property (
      dec_req && !inc_req && ctrl_reg.on && (cnt != RBC_CNT_RST)
      |=> cnt == $past(cnt) - 8'h01)
      else $error("decrement did not lower count by one");

   strobe_reads_zero_a : assert property (
      wb_ack_o && !wb_we_i && (wb_adr_i[7:2] == RBC_CTRL1_OFS[7:2])
      |-> wb_dat_o[RBC_DEC_BIT] == 1'b0)
      else $error("decrement bit read back as one");

   collision_holds_a : assert property (
      dec_req && inc_req |=> $stable(cnt))
      else $error("count moved on increment and decrement together");

   zero_write_a : assert property (
      acc.wr && ctrl_hit && !acc.wdata[RBC_DEC_BIT] && !inc_req && ctrl_reg.on
      |=> $stable(cnt))
      else $error("writing zero to decrement bit changed count");

   unused_bits_a : assert property (
      wb_ack_o && !wb_we_i && (wb_adr_i[7:2] == RBC_CTRL1_OFS[7:2])
      |-> wb_dat_o[3:1] == 3'h0)
      else $error("control bits 3 to 1 not zero");

   status_count_a : assert property (
      acc.rd && stat_hit ##1 1'b1
      |-> wb_ack_o && wb_dat_o[23:16] == $past(cnt))
      else $error("status read does not show count");

   auto_fc_on_a : assert property (
      ctrl_reg.on && ctrl_reg.auto_fc && (cnt >= full_wm_reg)
      ##1 ctrl_reg.on && ctrl_reg.auto_fc |=> pause_reg)
      else $error("pause not raised at full watermark");

   no_wrap_a : assert property (
      dec_req && !inc_req && (cnt == RBC_CNT_RST) |=> cnt == RBC_CNT_RST)
      else $error("count wrapped below zero");

   ack_single_a : assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   // Counting, clearing and flow control around the counter
   inc_by_one_a : assert property (
      inc_req && !dec_req && (cnt != RBC_CNT_MAX)
      |=> cnt == $past(cnt) + 8'h01)
      else $error("receive pulse did not raise count by one");

   count_ceiling_a : assert property (
      inc_req && !dec_req && (cnt == RBC_CNT_MAX)
      |=> cnt == RBC_CNT_MAX)
      else $error("count wrapped above its maximum");

   off_clears_a : assert property (
      !ctrl_reg.on
      |=> (cnt == RBC_CNT_RST) && !auto_fc_reg && !pause_reg)
      else $error("controller off left count or pause set");

   auto_fc_off_a : assert property (
      ctrl_reg.on && (cnt < full_wm_reg) && (cnt <= empty_wm_reg)
      |=> !auto_fc_reg)
      else $error("flow control not released at empty watermark");

   manual_pause_a : assert property (
      ctrl_reg.on && ctrl_reg.manual_fc
      |=> pause_reg)
      else $error("manual flow control did not raise pause");

   wmark_write_a : assert property (
      acc.wr && wmark_hit && acc.sel[1]
      |=> full_wm_reg == $past(acc.wdata[RBC_FULL_WM_LSB +: 8]))
      else $error("full watermark write did not land");

   // Bus handshake as seen by the master
   ack_answer_a : assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");

   write_keeps_data_a : assert property (
      wb_ack_o && wb_we_i
      |-> $stable(wb_dat_o))
      else $error("write disturbed held read data");

endmodule : rbc_top

`default_nettype wire

/* rbc_top_tb.sv */
// Self-checking testbench for the received buffer counter block
`timescale 1ns/100ps
`default_nettype none

module rbc_top_tb;
   import rbc_pkg::*;

   logic                     clk_i;
   logic                     rst_i;
   logic                     wb_cyc_i;
   logic                     wb_stb_i;
   logic                     wb_we_i;
   logic [RBC_ADR_W-1:0]     wb_adr_i;
   logic [RBC_SEL_W-1:0]     wb_sel_i;
   logic [RBC_DAT_W-1:0]     wb_dat_i;
   logic                     wb_ack_o;
   logic [RBC_DAT_W-1:0]     wb_dat_o;
   logic                     rx_buffer_filled_i;
   logic                     controller_on_o;
   logic                     receive_enable_o;
   logic [RBC_CNT_W-1:0]     received_buffer_count_o;
   logic                     flow_control_pause_o;
   int                       error_cnt;
   int                       cmp_count;

   // Control word with on and receive_enable set
   localparam logic [31:0] ON_RX = 32'h0000_8100;

   rbc_top i_dut (
      .clk_i                   (clk_i),
      .rst_i                   (rst_i),
      .wb_cyc_i                (wb_cyc_i),
      .wb_stb_i                (wb_stb_i),
      .wb_we_i                 (wb_we_i),
      .wb_adr_i                (wb_adr_i),
      .wb_sel_i                (wb_sel_i),
      .wb_dat_i                (wb_dat_i),
      .wb_ack_o                (wb_ack_o),
      .wb_dat_o                (wb_dat_o),
      .rx_buffer_filled_i      (rx_buffer_filled_i),
      .controller_on_o         (controller_on_o),
      .receive_enable_o        (receive_enable_o),
      .received_buffer_count_o (received_buffer_count_o),
      .flow_control_pause_o    (flow_control_pause_o)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   function automatic logic [31:0] stat(input logic [7:0] cnt, input logic fc);
      return {8'h00, cnt, 8'h00, 5'h00, cnt == 8'h00, cnt == 8'hFF, fc};
   endfunction : stat

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   // Request held until the edge that samples ack, then released
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] dat, output logic [31:0] rdat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      // Ack and read data are taken at the sampling edge; only the watchdog ends a hang
      do
      begin
         @(posedge clk_i);
      end
      while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb_xfer

   task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
      logic [31:0] unused;
      wb_xfer(1'b1, adr, sel, dat, unused);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      wb_xfer(1'b0, adr, 4'hF, 32'h0000_0000, d);
      check(what, d, exp);
   endtask : rd_chk

   // Receive pulses on k consecutive cycles
   task automatic rx_pulse(input int k);
      @(posedge clk_i);
      rx_buffer_filled_i <= 1'b1;
      repeat (k) @(posedge clk_i);
      rx_buffer_filled_i <= 1'b0;
      #1;
   endtask : rx_pulse

   task automatic cnt_chk(input logic [7:0] exp);
      check("count", {24'h0, received_buffer_count_o}, {24'h0, exp});
   endtask : cnt_chk

   task automatic t_reset();
      rd_chk("ctrl1", RBC_CTRL1_OFS, 32'h0000_0000);
      rd_chk("wmark", RBC_WMARK_OFS, 32'h0000_FF00);
      rd_chk("status", RBC_STAT_OFS, stat(8'h00, 1'b0));
      rd_chk("unmapped", 8'h0C, 32'h0000_0000);
   endtask : t_reset

   task automatic t_decrement();
      wr(RBC_CTRL1_OFS, 4'h3, ON_RX);
      check("on", {31'h0, controller_on_o}, 32'h1);
      // Manual pause through lane 0 only, strobe left at zero
      wr(RBC_CTRL1_OFS, 4'h1, 32'h0000_0010);
      @(posedge clk_i);
      check("pause", {31'h0, flow_control_pause_o}, 32'h1);
      wr(RBC_CTRL1_OFS, 4'h1, 32'h0000_0000);
      @(posedge clk_i);
      check("pause", {31'h0, flow_control_pause_o}, 32'h0);
      rx_pulse(3);
      cnt_chk(8'h03);
      rd_chk("status", RBC_STAT_OFS, stat(8'h03, 1'b0));
      wr(RBC_CTRL1_OFS, 4'h3, ON_RX | 32'h1);
      cnt_chk(8'h02);
      rd_chk("ctrl1", RBC_CTRL1_OFS, ON_RX);
      wr(RBC_CTRL1_OFS, 4'h3, ON_RX | 32'hE);
      cnt_chk(8'h02);
      rd_chk("ctrl1", RBC_CTRL1_OFS, ON_RX);
      // Strobe lane not enabled, so no decrement
      wr(RBC_CTRL1_OFS, 4'h2, ON_RX | 32'h1);
      cnt_chk(8'h02);
      check("rx_en", {31'h0, receive_enable_o}, 32'h1);
   endtask : t_decrement

   task automatic t_collide();
      fork
         wr(RBC_CTRL1_OFS, 4'h3, ON_RX | 32'h1);
         rx_pulse(1);
      join
      cnt_chk(8'h02);
   endtask : t_collide

   task automatic t_floor();
      repeat (2) wr(RBC_CTRL1_OFS, 4'h3, ON_RX | 32'h1);
      cnt_chk(8'h00);
      wr(RBC_CTRL1_OFS, 4'h3, ON_RX | 32'h1);
      cnt_chk(8'h00);
      rd_chk("status", RBC_STAT_OFS, stat(8'h00, 1'b0));
   endtask : t_floor

   task automatic t_flow();
      wr(RBC_WMARK_OFS, 4'h3, 32'h0000_0200);
      wr(RBC_CTRL1_OFS, 4'h3, ON_RX | 32'h80);
      rx_pulse(2);
      // Watermark flag, then pause register: two cycles
      repeat (2) @(posedge clk_i);
      #1;
      check("pause", {31'h0, flow_control_pause_o}, 32'h1);
      rd_chk("status", RBC_STAT_OFS, stat(8'h02, 1'b1));
      repeat (2) wr(RBC_CTRL1_OFS, 4'h3, ON_RX | 32'h81);
      @(posedge clk_i);
      #1;
      check("pause", {31'h0, flow_control_pause_o}, 32'h0);
      // Saturation at the top, then one step down
      rx_pulse(260);
      rd_chk("status", RBC_STAT_OFS, stat(8'hFF, 1'b1));
      wr(RBC_CTRL1_OFS, 4'h3, ON_RX | 32'h81);
      cnt_chk(8'hFE);
   endtask : t_flow

   task automatic t_off();
      wr(RBC_CTRL1_OFS, 4'h3, 32'h0000_0000);
      // Clear follows one cycle after the off write lands
      @(posedge clk_i);
      cnt_chk(8'h00);
      check("pause", {31'h0, flow_control_pause_o}, 32'h0);
      rx_pulse(1);
      cnt_chk(8'h00);
      check("on", {31'h0, controller_on_o}, 32'h0);
   endtask : t_off

   // Watchdog: the sequence needs well under 2000 cycles
   initial
   begin
      #(40 * 4000);
      error_cnt++;
      end_of_test();
   end

   initial
   begin
      rst_i              = 1'b1;
      wb_cyc_i           = 1'b0;
      wb_stb_i           = 1'b0;
      wb_we_i            = 1'b0;
      wb_adr_i           = 8'h00;
      wb_sel_i           = 4'h0;
      wb_dat_i           = 32'h0000_0000;
      rx_buffer_filled_i = 1'b0;
      error_cnt          = 0;
      cmp_count          = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_decrement();
      t_collide();
      t_floor();
      t_flow();
      t_off();
      end_of_test();
   end

endmodule : rbc_top_tb

`default_nettype wire
